// ===== src/pcgpm_gate.sv
// One glitch-free synchronous clock gate
`timescale 1ns/100ps
module pcgpm_gate
    import pcgpm_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    input  wire logic phase_in,
    input  wire logic en_in,
    output logic      gclk_out
);
    logic en_q;

    // Enable only moves while the divided clock is low, so no pulse is cut
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            en_q <= 1'b1;
        end else if (ce_in && !phase_in) begin
            en_q <= en_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            gclk_out <= 1'b0;
        end else if (ce_in) begin
            gclk_out <= phase_in & en_q;
        end
    end
endmodule

// ===== src/pcgpm_pkg.sv
// Package: register map, field layout and mode encodings for the clock gating block
package pcgpm_pkg;

    // ************************************************************
    // Register bus
    // ************************************************************
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Printed offsets are register indices
    localparam logic [3:0] OFF_PCE  = 4'hC;
    localparam logic [3:0] OFF_ISAH = 4'hD;
    localparam logic [3:0] OFF_SHORT_IO_RELOCATION = 4'hE;
    localparam logic [3:0] OFF_CTRL = 4'hF;
    localparam logic [3:0] OFF_STAT = 4'h9;

    // ************************************************************
    // Peripheral clock gate layout
    // ************************************************************
    localparam int unsigned N_GATES = 9;
    localparam logic [15:0] PCE_IMPL_MASK  = 16'h357D;
    localparam logic [15:0] PCE_RESET      = 16'hFFFF;
    localparam logic [15:0] ISAH_RESET     = 16'hFFFF;
    localparam logic [15:0] SHORT_IO_RELOCATION_RESET     = 16'hFFFF;
    localparam logic [15:0] ISAH_MASK      = 16'h0003;
    localparam logic [15:0] CTRL_RESET     = 16'h0002;
    localparam int unsigned CTRL_CLKDIS    = 0;
    localparam int unsigned CTRL_DBGEN     = 1;

    // Bit positions of the gates inside the enable register, lowest gate first
    localparam logic [3:0] GATE_POS [N_GATES] = '{
        4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hD
    };
    // CAN controller sits at position 12, handled apart for stop wake
    localparam logic [3:0] CAN_POS = 4'hC;

    // ************************************************************
    // Relocation
    // ************************************************************
    localparam logic [17:0] RELOC_TOP   = 18'h3FFFF;
    localparam int unsigned RELOC_DELAY = 5;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned MASTER_MHZ   = 120;
    localparam int unsigned SYS_MAX_MHZ  = 60;
    localparam int unsigned SYS_DIV      = MASTER_MHZ / SYS_MAX_MHZ;

    typedef enum logic [1:0] {
        PCGPM_RUN  = 2'b00,
        PCGPM_WAIT = 2'b01,
        PCGPM_STOP = 2'b11
    } pcgpm_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } pcgpm_bus_t;

    typedef struct packed {
        logic       can_traffic;
        logic       ext_irq;
        logic       wdog_rst;
        logic       periph_irq;
    } pcgpm_wake_t;

endpackage

// ===== src/pcgpm_reloc.sv
// Relocation base delay line for short I/O addressing
`timescale 1ns/100ps
module pcgpm_reloc
    import pcgpm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic [17:0] base_in,
    input  wire logic [5:0]  offs_in,
    output logic [23:0]      addr_out,
    output logic [17:0]      eff_base_out
);
    logic [17:0] pipe_q [RELOC_DELAY];

    // New base reaches short accesses after the pipeline delay
    genvar i;
    generate
        for (i = 0; i < RELOC_DELAY; i++) begin : g_stage
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    pipe_q[i] <= RELOC_TOP;
                end else if (ce_in) begin
                    pipe_q[i] <= (i == 0) ? base_in : pipe_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_out <= {RELOC_TOP, 6'h00};
        end else if (ce_in) begin
            addr_out <= {pipe_q[RELOC_DELAY-1], offs_in};
        end
    end

    assign eff_base_out = pipe_q[RELOC_DELAY-1];
endmodule

// ===== src/pcgpm_top.sv
// Peripheral clock gating, short I/O relocation and power mode control
`timescale 1ns/100ps
module pcgpm_top
    import pcgpm_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire logic              wait_instr_in,
    input  wire logic              stop_instr_in,
    input  wire logic              periph_irq_in,
    input  wire logic              can_traffic_in,
    input  wire logic              ext_irq_in,
    input  wire logic              wdog_rst_in,
    input  wire logic              ext_mem_flag_in,
    input  wire logic [5:0]        short_offs_in,
    output logic [DATA_W-1:0]      rdata_out,
    output logic [15:0]            periph_clk_out,
    output logic                   core_clk_out,
    output logic                   mem_clk_out,
    output logic                   sim_clk_out,
    output logic                   wdog_clk_out,
    output logic                   clk_out_en_out,
    output logic                   debug_clk_out,
    output logic                   debug_access_out,
    output logic [23:0]            short_addr_out,
    output logic [1:0]             mode_out
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] pce_q;
    logic [1:0]  isah_q;
    logic [15:0] short_io_relocation_q;
    logic [1:0]  ctrl_q;
    logic        phase_q;
    pcgpm_mode_t mode_q;
    pcgpm_mode_t mode_d;
    pcgpm_bus_t  bus;
    pcgpm_wake_t wake;
    logic [17:0] eff_base;
    logic [23:0] short_addr;
    logic [15:0] pce_rd;
    logic [15:0] periph_gclk;
    logic        core_gclk;
    logic        mem_gclk;
    logic        sel_pce;
    logic        sel_isah;
    logic        sel_short_io_relocation;
    logic        sel_ctrl;
    logic        wait_wake;
    logic        stop_wake;
    logic        periph_run;
    logic        core_run;

    assign bus  = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
    assign wake = '{can_traffic: can_traffic_in, ext_irq: ext_irq_in,
                    wdog_rst: wdog_rst_in, periph_irq: periph_irq_in};

    // Reserved positions forced to one on readback
    assign pce_rd = pce_q | ~PCE_IMPL_MASK;

    // ************************************************************
    // Register decode
    // ************************************************************
    // One select per writable register; a frozen clock enable blocks every write
    assign sel_pce  = ce_in && bus.wr && bus.addr == OFF_PCE;
    assign sel_isah = ce_in && bus.wr && bus.addr == OFF_ISAH;
    assign sel_short_io_relocation = ce_in && bus.wr && bus.addr == OFF_SHORT_IO_RELOCATION;
    assign sel_ctrl = ce_in && bus.wr && bus.addr == OFF_CTRL;

    // ************************************************************
    // Register writes
    // ************************************************************
    // All ones after reset, so every peripheral starts clocked
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pce_q <= PCE_RESET;
        end else if (sel_pce) begin
            pce_q <= (bus.wdata & PCE_IMPL_MASK) | ~PCE_IMPL_MASK;
        end
    end

    // Only the two top address bits are stored; the rest read back as ones
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            isah_q <= ISAH_RESET[1:0];
        end else if (sel_isah) begin
            isah_q <= bus.wdata[1:0];
        end
    end

    // Low half of the base: address bits 21 down to 6
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            short_io_relocation_q <= SHORT_IO_RELOCATION_RESET;
        end else if (sel_short_io_relocation) begin
            short_io_relocation_q <= bus.wdata;
        end
    end

    // Bit 0 disables the clock output, bit 1 enables the debug clock
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RESET[1:0];
        end else if (sel_ctrl) begin
            ctrl_q <= bus.wdata[1:0];
        end
    end

    // ************************************************************
    // Register reads, data valid the cycle after the strobe
    // ************************************************************
    // Zero outside the answer cycle while ce_in is high; a frozen clock enable holds the last data on the bus
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (ce_in) begin
            if (bus.rd) begin
                unique case (bus.addr)
                    OFF_PCE:  rdata_out <= pce_rd;
                    OFF_ISAH: rdata_out <= {14'h3FFF, isah_q};
                    OFF_SHORT_IO_RELOCATION: rdata_out <= short_io_relocation_q;
                    OFF_CTRL: rdata_out <= {14'h0000, ctrl_q};
                    OFF_STAT: rdata_out <= {13'h0000, debug_access_out, mode_q};
                    default:  rdata_out <= 16'h0000;
                endcase
            end else begin
                rdata_out <= 16'h0000;
            end
        end
    end

    // ************************************************************
    // Clock divider: system rate is half the master rate
    // ************************************************************
    // Every derived clock is a registered copy of this phase; clocks through pcgpm_gate pass two flops, the rest one (debug included), so they run in opposite phase
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            phase_q <= 1'b0;
        end else if (ce_in) begin
            phase_q <= ~phase_q;
        end
    end

    // ************************************************************
    // Power mode sequencer
    // ************************************************************
    // Resets other than the watchdog come in through rst_n_in
    assign wait_wake  = wake.periph_irq || wake.ext_irq || wake.wdog_rst;
    // Peripheral interrupts cannot end Stop: their clocks are already gated off
    assign stop_wake  = wake.can_traffic || wake.ext_irq || wake.wdog_rst;
    assign periph_run = mode_q != PCGPM_STOP;
    assign core_run   = mode_q == PCGPM_RUN;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PCGPM_RUN: begin
                // Stop wins when both sleep pulses arrive together
                if (stop_instr_in) begin
                    mode_d = PCGPM_STOP;
                end else if (wait_instr_in) begin
                    mode_d = PCGPM_WAIT;
                end
            end
            PCGPM_WAIT: begin
                // Any unmasked peripheral interrupt resumes execution
                if (wait_wake) begin
                    mode_d = PCGPM_RUN;
                end
            end
            PCGPM_STOP: begin
                // CAN wake loses the waking frame: its gate was off
                if (stop_wake) begin
                    mode_d = PCGPM_RUN;
                end
            end
            default: mode_d = PCGPM_RUN;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mode_q <= PCGPM_RUN;
        end else if (ce_in) begin
            mode_q <= mode_d;
        end
    end

    // ************************************************************
    // Peripheral gates
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_pce
            if (PCE_IMPL_MASK[g]) begin : g_impl
                pcgpm_gate u_gate (
                    .clk_in   (clk_in),
                    .rst_n_in (rst_n_in),
                    .ce_in    (ce_in),
                    .phase_in (phase_q),
                    // Stop withholds peripheral clocks; Run and Wait keep them
                    .en_in    (pce_q[g] && periph_run),
                    .gclk_out (periph_gclk[g])
                );
            end else begin : g_none
                // Reserved positions have no gate and stay low
                assign periph_gclk[g] = 1'b0;
            end
        end
    endgenerate

    // Core and memory share one enable but keep separate gates
    pcgpm_gate u_core_gate (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .phase_in (phase_q),
        .en_in    (core_run),
        .gclk_out (core_gclk)
    );

    pcgpm_gate u_mem_gate (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .phase_in (phase_q),
        .en_in    (core_run),
        .gclk_out (mem_gclk)
    );

    // ************************************************************
    // Output registers
    // ************************************************************
    // Every clock leaves through a flop so the outputs carry no gate logic
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            periph_clk_out <= 16'h0000;
        end else if (ce_in) begin
            periph_clk_out <= periph_gclk;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            core_clk_out <= 1'b0;
            mem_clk_out  <= 1'b0;
        end else if (ce_in) begin
            core_clk_out <= core_gclk;
            mem_clk_out  <= mem_gclk;
        end
    end

    // Integration block and watchdog stay clocked in every mode
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sim_clk_out  <= 1'b0;
            wdog_clk_out <= 1'b0;
        end else if (ce_in) begin
            sim_clk_out  <= phase_q;
            wdog_clk_out <= phase_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clk_out_en_out <= 1'b1;
        end else if (ce_in) begin
            clk_out_en_out <= ~ctrl_q[CTRL_CLKDIS];
        end
    end

    // Debug clock passes one flop fewer than the core clock, so it runs in opposite phase to it
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            debug_clk_out <= 1'b0;
        end else if (ce_in) begin
            debug_clk_out <= ctrl_q[CTRL_DBGEN] & phase_q;
        end
    end

    // Limitation: halves are written apart, so a mixed base is briefly live
    pcgpm_reloc u_reloc (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .ce_in        (ce_in),
        .base_in      ({isah_q, short_io_relocation_q}),
        .offs_in      (short_offs_in),
        .addr_out     (short_addr),
        .eff_base_out (eff_base)
    );

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            short_addr_out <= {RELOC_TOP, 6'h00};
        end else if (ce_in) begin
            short_addr_out <= short_addr;
        end
    end

    // Relocated base plus external memory hides the debug registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            debug_access_out <= 1'b1;
        end else if (ce_in) begin
            debug_access_out <= !(eff_base != RELOC_TOP && ext_mem_flag_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mode_out <= PCGPM_RUN;
        end else if (ce_in) begin
            mode_out <= mode_q;
        end
    end
endmodule

// ===== tb/pcgpm_core_model.sv
// Partner: core model issuing sleep instructions and counting core clock edges
`timescale 1ns/100ps
module pcgpm_core_model (
    input  wire logic   clk_in,
    input  wire logic   rst_n_in,
    input  wire logic   core_clk_in,
    input  wire logic   req_wait_in,
    input  wire logic   req_stop_in,
    output logic        wait_instr_out,
    output logic        stop_instr_out,
    output logic [15:0] core_edges_out
);
    logic core_clk_q;
    // ************
    // Sleep issue
    // ************
    // One-cycle pulse as the sleep instruction retires
    always_ff @(posedge clk_in) begin
        wait_instr_out <= rst_n_in && req_wait_in;
        stop_instr_out <= rst_n_in && req_stop_in;
    end
    // Edges seen only while the core is really clocked
    always_ff @(posedge clk_in) begin
        core_clk_q <= core_clk_in;
        if (!rst_n_in) begin
            core_edges_out <= 16'h0000;
        end else if (core_clk_in && !core_clk_q) begin
            core_edges_out <= core_edges_out + 16'h0001;
        end
    end
endmodule

// ===== tb/pcgpm_top_asserts.sv
// Checker: port-level assertions for the clock gating block
`timescale 1ns/100ps
module pcgpm_top_asserts
    import pcgpm_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              rd_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              can_traffic_in,
    input  wire logic              ext_irq_in,
    input  wire logic              wdog_rst_in,
    input  wire logic              ext_mem_flag_in,
    input  wire logic [DATA_W-1:0] rdata_out,
    input  wire logic [15:0]       periph_clk_out,
    input  wire logic              core_clk_out,
    input  wire logic              mem_clk_out,
    input  wire logic              sim_clk_out,
    input  wire logic              wdog_clk_out,
    input  wire logic              debug_access_out,
    input  wire logic [1:0]        mode_out
);
    // ************
    // Assertions
    // ************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic quiet = !can_traffic_in && !ext_irq_in && !wdog_rst_in;
    // Stop mode seen with every wake source idle
    sequence s_stop_idle;
        mode_out == PCGPM_STOP && quiet;
    endsequence
    AST_RSV_GATES: assert property ((periph_clk_out & ~PCE_IMPL_MASK) == 16'h0000)
        else $error("clock on a reserved gate position");
    AST_PCE_RSV_READ: assert property (rd_in && addr_in == OFF_PCE |=> (rdata_out | PCE_IMPL_MASK) == 16'hFFFF)
        else $error("reserved enable bits not read as one");
    AST_ISAH_READ: assert property (rd_in && addr_in == OFF_ISAH |=> rdata_out[15:2] == 14'h3FFF)
        else $error("upper relocation high bits not read as one");
    AST_STOP_HOLD: assert property (s_stop_idle ##1 s_stop_idle |=> mode_out == PCGPM_STOP)
        else $error("stop left without a wake source");
    AST_SLEEP_CORE: assert property ((mode_out != PCGPM_RUN) [*3] |-> !core_clk_out && !mem_clk_out)
        else $error("core or memory clock running while asleep");
    AST_RUN_CORE: assert property ((mode_out == PCGPM_RUN) [*4] |-> core_clk_out != $past(core_clk_out))
        else $error("core clock stalled in run");
    AST_SYSTEM_CLOCK_NET: assert property ($past(rst_n_in) && $past(rst_n_in, 2) |-> sim_clk_out != $past(sim_clk_out))
        else $error("system clock not at half rate");
    AST_WDOG_CLK: assert property ($past(rst_n_in) && $past(rst_n_in, 2) |-> wdog_clk_out != $past(wdog_clk_out))
        else $error("watchdog clock stalled");
    AST_DBG_LOCAL: assert property (!ext_mem_flag_in [*3] |-> debug_access_out)
        else $error("debug access lost without external flag");
endmodule

bind pcgpm_top pcgpm_top_asserts u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .rd_in(rd_in), .addr_in(addr_in),
    .can_traffic_in(can_traffic_in), .ext_irq_in(ext_irq_in), .wdog_rst_in(wdog_rst_in),
    .ext_mem_flag_in(ext_mem_flag_in), .rdata_out(rdata_out), .periph_clk_out(periph_clk_out),
    .core_clk_out(core_clk_out), .mem_clk_out(mem_clk_out), .sim_clk_out(sim_clk_out),
    .wdog_clk_out(wdog_clk_out), .debug_access_out(debug_access_out), .mode_out(mode_out)
);

// ===== tb/pcgpm_top_test.sv
// Testbench: register, gating, relocation and power mode scenarios
`timescale 1ns/100ps
module pcgpm_top_test
    import pcgpm_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, irq = 1'b0;
    logic        can = 1'b0, ext = 1'b0, wdog = 1'b0, emf = 1'b0, req_w = 1'b0, req_s = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [5:0]  offs = 6'h00;
    logic        wi, si, core_clk, mem_clk, clko_en, dbg_clk, dbg_acc;
    logic [15:0] rdata, pclk, edges;
    logic [23:0] saddr;
    logic [1:0]  mode;
    int          num_errors = 0;
    int          tests_run = 0;
    always #4 clk = ~clk;

    pcgpm_top uut (.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .wait_instr_in(wi), .stop_instr_in(si), .periph_irq_in(irq),
        .can_traffic_in(can), .ext_irq_in(ext), .wdog_rst_in(wdog), .ext_mem_flag_in(emf),
        .short_offs_in(offs), .rdata_out(rdata), .periph_clk_out(pclk), .core_clk_out(core_clk),
        .mem_clk_out(mem_clk), .sim_clk_out(), .wdog_clk_out(), .clk_out_en_out(clko_en),
        .debug_clk_out(dbg_clk), .debug_access_out(dbg_acc), .short_addr_out(saddr), .mode_out(mode));
    pcgpm_core_model core (.clk_in(clk), .rst_n_in(rst_n), .core_clk_in(core_clk), .req_wait_in(req_w),
        .req_stop_in(req_s), .wait_instr_out(wi), .stop_instr_out(si), .core_edges_out(edges));

    // ************
    // Helpers
    // ************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(24'(rdata), 24'(exp));
    endtask
    // Toggle pattern over one cycle: debug, core, then peripheral clocks
    task automatic tog(output logic [17:0] t);
        logic [17:0] a;
        cyc(1);
        a = {dbg_clk, core_clk, pclk};
        cyc(1);
        t = a ^ {dbg_clk, core_clk, pclk};
    endtask
    task automatic sleep(input logic s);
        @(posedge clk);
        req_s <= s;
        req_w <= !s;
        @(posedge clk);
        req_s <= 1'b0;
        req_w <= 1'b0;
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 20) begin
            cyc(1);
            n++;
        end
        chk(24'(mode), 24'(m));
        if (mode !== m) begin
            give_verdict();
        end
    endtask

    // ************
    // Scenarios
    // ************
    initial begin
        logic [17:0] t;
        logic [15:0] b;
        logic [15:0] e;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        chk(saddr, 24'hFFFFC0);
        chk(24'({dbg_acc, clko_en}), 24'h3);
        rd_reg(OFF_PCE, PCE_RESET);
        rd_reg(OFF_ISAH, ISAH_RESET);
        rd_reg(OFF_SHORT_IO_RELOCATION, SHORT_IO_RELOCATION_RESET);
        rd_reg(OFF_CTRL, CTRL_RESET);
        rd_reg(4'h0, 16'h0000);
        for (int g = 0; g <= N_GATES; g++) begin
            b = 16'h0001 << ((g == N_GATES) ? CAN_POS : GATE_POS[g]);
            wr_reg(OFF_PCE, b);
            rd_reg(OFF_PCE, b | ~PCE_IMPL_MASK);
            cyc(6);
            tog(t);
            chk(24'(t[15:0]), 24'(b));
        end
        wr_reg(OFF_PCE, 16'hFFFF);
        wr_reg(OFF_CTRL, 16'h0001);
        tog(t);
        chk(24'({clko_en, t[17]}), 24'h0);
        wr_reg(OFF_CTRL, 16'h0002);
        tog(t);
        chk(24'({clko_en, t[17]}), 24'h3);
        wr_reg(OFF_SHORT_IO_RELOCATION, 16'h1234);
        for (int k = 0; k < 5; k++) begin
            cyc(1);
            chk(saddr, 24'hFFFFC0);
        end
        cyc(2);
        chk(saddr, 24'hC48D00);
        wr_reg(OFF_ISAH, 16'h0000);
        rd_reg(OFF_ISAH, 16'hFFFC);
        offs <= 6'h15;
        emf <= 1'b1;
        cyc(8);
        chk(saddr, 24'h048D15);
        chk(24'(dbg_acc), 24'h0);
        wr_reg(OFF_ISAH, 16'h0003);
        wr_reg(OFF_SHORT_IO_RELOCATION, 16'hFFFF);
        cyc(8);
        chk(24'(dbg_acc), 24'h1);
        emf <= 1'b0;
        sleep(1'b0);
        wait_mode(PCGPM_WAIT);
        rd_reg(OFF_STAT, 16'h0005);
        e = edges;
        tog(t);
        chk(24'(t[16:0]), 24'(PCE_IMPL_MASK));
        chk(24'(edges - e), 24'h0);
        irq <= 1'b1;
        wait_mode(PCGPM_RUN);
        irq <= 1'b0;
        cyc(2);
        tog(t);
        chk(24'(t[16]), 24'h1);
        for (int w = 0; w < 3; w++) begin
            sleep(1'b1);
            wait_mode(PCGPM_STOP);
            irq <= 1'b1;
            cyc(4);
            chk(24'({mode, core_clk, mem_clk}), 24'hC);
            chk(24'(pclk), 24'h0);
            irq <= 1'b0;
            {wdog, ext, can} <= 3'b001 << w;
            wait_mode(PCGPM_RUN);
            {wdog, ext, can} <= 3'b000;
            cyc(2);
        end
        give_verdict();
    end
endmodule
